// File: hw/dtp_io_point.sv
// Digital I/O point: input sensing and time-proportioned output
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps

module dtp_io_point #(
    parameter int SlotCycles = dtp_pkg::SLOT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire dtp_pkg::dtp_bus_t bus,
    output logic [31:0] rdata,
    input wire dtp_pkg::dtp_pins_t pins,
    output logic ioIn,
    output logic dedIn,
    output logic fieldOut,
    output logic outEn
);

    // ============================================================
    // State
    typedef struct packed {
        dtp_pkg::dtp_mode_t mode;
        logic [3:0] ctrl;
        logic [9:0] per;
        logic [9:0] low;
        logic [9:0] high;
        logic [9:0] cmd;
        logic [23:0] base;
        logic [9:0] rep;
        logic [9:0] slot;
        logic [9:0] onSlots;
        logic [9:0] acc;
        logic [1:0] lineCnt;
        logic grpOn;
        dtp_pkg::dtp_pins_t syncA;
        dtp_pkg::dtp_pins_t syncB;
        logic acPrev;
        logic ioIn;
        logic dedIn;
        logic fieldOut;
        logic outEn;
        logic [31:0] rdata;
    } dtp_state_t;

    dtp_state_t s_reg;
    dtp_state_t s_next;

    // Clamp a written percentage to full scale
    function automatic logic [9:0] clampPct(input logic [31:0] v);
        clampPct = (v > 32'(dtp_pkg::FULL)) ? dtp_pkg::FULL : v[9:0];
    endfunction

    // ============================================================
    // Power scaling
    logic [1:0] dirCfg;
    logic signed [11:0] span;
    logic signed [22:0] prod;
    logic signed [22:0] quo;
    logic signed [22:0] effSum;
    logic [9:0] effPwr;
    logic acEdge;
    logic slotEnd;
    logic periodEnd;

    assign dirCfg = s_reg.ctrl[dtp_pkg::CTRL_DIR_LSB +: 2];
    // Linear map of command onto low..high span
    assign span = $signed({2'h0, s_reg.high}) - $signed({2'h0, s_reg.low});
    assign prod = span * $signed({1'h0, s_reg.cmd});
    assign quo = prod / $signed({13'h0000, dtp_pkg::FULL});
    // Zero command gives low, full gives high
    assign effSum = $signed({13'h0000, s_reg.low}) + quo;
    assign effPwr = effSum[9:0];

    // Edge from the second sync stage and its delayed copy only
    assign acEdge = s_reg.syncB.acLine & ~s_reg.acPrev;
    assign slotEnd = (s_reg.base == 24'(SlotCycles - 1));
    assign periodEnd = slotEnd && (s_reg.rep >= s_reg.per - dtp_pkg::PER_MIN)
        && (s_reg.slot == dtp_pkg::LAST_SLOT);

    // ============================================================
    // Next state
    always_comb
    begin
        logic [10:0] sum;
        dtp_pkg::dtp_mode_t wantMode;
        sum = 11'h000;
        wantMode = dtp_pkg::MD_INPUT;
        s_next = s_reg;
        // Two-stage synchronisers on all field pins
        s_next.syncA = pins;
        s_next.syncB = s_reg.syncA;
        s_next.acPrev = s_reg.syncB.acLine;
        s_next.rdata = 32'h0000_0000;

        // Register writes; unmapped writes are dropped
        if (bus.wr)
        begin
            case (bus.addr)
                dtp_pkg::ADDR_CTRL: s_next.ctrl = bus.wdata[3:0];
                dtp_pkg::ADDR_PERIOD:
                begin
                    // Out-of-range periods pinned to the legal span
                    if (bus.wdata < 32'(dtp_pkg::PER_MIN))
                        s_next.per = dtp_pkg::PER_MIN;
                    else if (bus.wdata > 32'(dtp_pkg::PER_MAX))
                        s_next.per = dtp_pkg::PER_MAX;
                    else
                        s_next.per = bus.wdata[9:0];
                end
                dtp_pkg::ADDR_LOW: s_next.low = clampPct(bus.wdata);
                dtp_pkg::ADDR_HIGH: s_next.high = clampPct(bus.wdata);
                dtp_pkg::ADDR_CMD: s_next.cmd = clampPct(bus.wdata);
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end

        // Register reads; unmapped reads return zero
        if (bus.rd)
        begin
            case (bus.addr)
                dtp_pkg::ADDR_CTRL: s_next.rdata = {28'h000_0000, s_reg.ctrl};
                dtp_pkg::ADDR_PERIOD: s_next.rdata = {22'h00_0000, s_reg.per};
                dtp_pkg::ADDR_LOW: s_next.rdata = {22'h00_0000, s_reg.low};
                dtp_pkg::ADDR_HIGH: s_next.rdata = {22'h00_0000, s_reg.high};
                dtp_pkg::ADDR_CMD: s_next.rdata = {22'h00_0000, s_reg.cmd};
                dtp_pkg::ADDR_STATUS:
                begin
                    s_next.rdata[dtp_pkg::STAT_PWR_LSB +: 10] = effPwr;
                    s_next.rdata[0] = s_reg.ioIn;
                    s_next.rdata[1] = s_reg.dedIn;
                    s_next.rdata[2] = s_reg.fieldOut;
                end
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Mode pick: steady ends, or the chosen time base
        if (dirCfg != dtp_pkg::DIR_OUTPUT)
            wantMode = dtp_pkg::MD_INPUT;
        else if (effPwr == 10'h000 || effPwr >= dtp_pkg::FULL)
            wantMode = dtp_pkg::MD_STEADY;
        else if (s_reg.ctrl[dtp_pkg::CTRL_TB_BIT])
            wantMode = dtp_pkg::MD_VAR;
        else
            wantMode = dtp_pkg::MD_FIXED;
        s_next.mode = wantMode;

        // Fixed base: slot prescaler, then 1000 slots a period
        if (wantMode == dtp_pkg::MD_FIXED && s_reg.mode != dtp_pkg::MD_FIXED)
        begin
            // Fresh period on entry so the first one is full length
            s_next.base = 24'h00_0000;
            s_next.rep = 10'h000;
            s_next.slot = 10'h000;
            s_next.onSlots = effPwr;
        end
        else if (wantMode == dtp_pkg::MD_FIXED)
        begin
            s_next.base = s_reg.base + 24'h00_0001;
            if (slotEnd)
            begin
                s_next.base = 24'h00_0000;
                s_next.rep = s_reg.rep + 10'h001;
                if (s_reg.rep >= s_reg.per - dtp_pkg::PER_MIN)
                begin
                    s_next.rep = 10'h000;
                    s_next.slot = s_reg.slot + 10'h001;
                    if (s_reg.slot == dtp_pkg::LAST_SLOT)
                    begin
                        // Restart and take the present scaled power
                        s_next.slot = 10'h000;
                        s_next.onSlots = effPwr;
                    end
                end
            end
        end

        // Variable base: decide once per group of three line cycles
        if (wantMode == dtp_pkg::MD_VAR && acEdge)
        begin
            s_next.lineCnt = (s_reg.lineCnt == dtp_pkg::LINE_LAST)
                ? 2'h0 : s_reg.lineCnt + 2'h1;
            if (s_reg.lineCnt == 2'h0)
            begin
                // Error accumulator keeps the long-run average exact
                sum = {1'h0, s_reg.acc} + {1'h0, effPwr};
                if (sum >= {1'h0, dtp_pkg::FULL})
                begin
                    s_next.grpOn = 1'b1;
                    s_next.acc = 10'(sum - {1'h0, dtp_pkg::FULL});
                end
                else
                begin
                    s_next.grpOn = 1'b0;
                    s_next.acc = sum[9:0];
                end
            end
        end
        else if (wantMode != dtp_pkg::MD_VAR)
        begin
            s_next.lineCnt = 2'h0;
            s_next.grpOn = 1'b0;
        end

        // Field drive from the chosen mode
        unique case (wantMode)
            dtp_pkg::MD_INPUT: s_next.fieldOut = 1'b0;
            dtp_pkg::MD_STEADY: s_next.fieldOut = (effPwr >= dtp_pkg::FULL);
            dtp_pkg::MD_FIXED: s_next.fieldOut = (s_next.slot < s_next.onSlots);
            dtp_pkg::MD_VAR: s_next.fieldOut = s_next.grpOn;
        endcase
        s_next.outEn = (dirCfg == dtp_pkg::DIR_OUTPUT);

        // Transmitted input signals
        unique case (dirCfg)
            dtp_pkg::DIR_CONTACT: s_next.ioIn = s_reg.syncB.ioContact;
            dtp_pkg::DIR_VOLT: s_next.ioIn = s_reg.syncB.ioVolt;
            default: s_next.ioIn = 1'b0;
        endcase
        s_next.dedIn = s_reg.ctrl[dtp_pkg::CTRL_DED_BIT]
            ? s_reg.syncB.dedVolt : s_reg.syncB.dedContact;
    end

    // ============================================================
    // State register, frozen while ce is low
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.ctrl <= dtp_pkg::CTRL_RST;
            s_reg.per <= dtp_pkg::PER_RST;
            s_reg.low <= dtp_pkg::LOW_RST;
            s_reg.high <= dtp_pkg::HIGH_RST;
            s_reg.cmd <= dtp_pkg::CMD_RST;
        end
        else if (ce)
            s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign rdata = s_reg.rdata;
    assign ioIn = s_reg.ioIn;
    assign dedIn = s_reg.dedIn;
    assign fieldOut = s_reg.fieldOut;
    assign outEn = s_reg.outEn;

    // ============================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence lineGroupStart;
        ce && s_next.mode == dtp_pkg::MD_VAR && acEdge && s_reg.lineCnt == 2'h0;
    endsequence

    sequence fixedWrap;
        ce && s_reg.mode == dtp_pkg::MD_FIXED && periodEnd;
    endsequence

    sequence statusRead;
        ce && bus.rd && bus.addr == dtp_pkg::ADDR_STATUS;
    endsequence

    dir_drive_a: assert property (ce |=> outEn == ($past(dirCfg) == dtp_pkg::DIR_OUTPUT))
        else $error("drive enable does not follow direction");
    ded_select_a: assert property (ce && s_reg.ctrl[dtp_pkg::CTRL_DED_BIT]
        |=> dedIn == $past(s_reg.syncB.dedVolt))
        else $error("dedicated input ignores voltage selection");
    contact_echo_a: assert property (ce && dirCfg == dtp_pkg::DIR_CONTACT
        |=> ioIn == $past(s_reg.syncB.ioContact) && !fieldOut)
        else $error("contact input not echoed");
    volt_echo_a: assert property (ce && dirCfg == dtp_pkg::DIR_VOLT
        |=> ioIn == $past(s_reg.syncB.ioVolt) && !outEn)
        else $error("voltage input not echoed");
    steady_ends_a: assert property (ce && dirCfg == dtp_pkg::DIR_OUTPUT
        && (effPwr == 10'h000 || effPwr >= dtp_pkg::FULL)
        |=> fieldOut == ($past(effPwr) >= dtp_pkg::FULL))
        else $error("steady command not held");
    acc_bound_a: assert property (s_reg.acc < dtp_pkg::FULL)
        else $error("average error accumulator overflow");
    fixed_duty_a: assert property (ce && s_reg.mode == dtp_pkg::MD_FIXED
        && s_next.mode == dtp_pkg::MD_FIXED
        |=> fieldOut == (s_reg.slot < s_reg.onSlots))
        else $error("fixed base duty split wrong");
    period_range_a: assert property (s_reg.per >= dtp_pkg::PER_MIN
        && s_reg.per <= dtp_pkg::PER_MAX)
        else $error("fixed period out of range");
    line_hold_a: assert property (ce && s_reg.mode == dtp_pkg::MD_VAR
        && s_next.mode == dtp_pkg::MD_VAR && !(acEdge && s_reg.lineCnt == 2'h0)
        |=> $stable(s_reg.grpOn))
        else $error("line group switched mid group");
    line_decide_a: assert property (lineGroupStart
        |=> s_reg.grpOn == ($past(s_reg.acc) + $past(effPwr) >= 11'(dtp_pkg::FULL)))
        else $error("line group decision wrong");
    scale_ends_a: assert property ((s_reg.cmd == 10'h000 |-> effPwr == s_reg.low)
        and (s_reg.cmd == dtp_pkg::FULL |-> effPwr == s_reg.high))
        else $error("scale end points wrong");
    scale_span_a: assert property (effPwr >= ((s_reg.low < s_reg.high) ? s_reg.low : s_reg.high)
        && effPwr <= ((s_reg.low < s_reg.high) ? s_reg.high : s_reg.low))
        else $error("scaled power outside span");
    period_reload_a: assert property (fixedWrap ##0 (s_next.mode == dtp_pkg::MD_FIXED)
        |=> s_reg.onSlots == $past(effPwr) && s_reg.slot == 10'h000)
        else $error("period restart missed");

    // ============================================================
    // Checks on the bus, the freeze, the input direction and the dedicated input
    // Read data stands one cycle only, so an idle bus reads zero
    rdata_idle_a: assert property (ce && !bus.rd |=> rdata == 32'h0000_0000)
        else $error("read data left standing");
    status_power_a: assert property (statusRead
        |=> rdata[dtp_pkg::STAT_PWR_LSB +: 10] == $past(effPwr))
        else $error("status power differs from scaled power");
    period_clamp_a: assert property (ce && bus.wr && bus.addr == dtp_pkg::ADDR_PERIOD
        && bus.wdata > 32'(dtp_pkg::PER_MAX)
        |=> s_reg.per == dtp_pkg::PER_MAX)
        else $error("long period not pinned");
    // A frozen block must not move, or slot timing would drift
    freeze_hold_a: assert property (!ce |=> $stable(s_reg))
        else $error("state moved while frozen");
    input_idle_a: assert property (ce && dirCfg != dtp_pkg::DIR_OUTPUT
        |=> !fieldOut && !outEn)
        else $error("input point drives the field");
    ded_contact_a: assert property (ce && !s_reg.ctrl[dtp_pkg::CTRL_DED_BIT]
        |=> dedIn == $past(s_reg.syncB.dedContact))
        else $error("dedicated input ignores contact selection");

    // ============================================================
    // Checks on the two time bases
    // Entry starts a whole period with the present duty
    fixed_entry_a: assert property (ce && s_reg.mode != dtp_pkg::MD_FIXED
        && s_next.mode == dtp_pkg::MD_FIXED
        |=> s_reg.slot == 10'h000 && s_reg.onSlots == $past(effPwr) && fieldOut)
        else $error("fixed base entry not a fresh period");
    duty_hold_a: assert property (ce && s_reg.mode == dtp_pkg::MD_FIXED
        && s_next.mode == dtp_pkg::MD_FIXED && !periodEnd
        |=> $stable(s_reg.onSlots))
        else $error("duty changed inside a period");
    var_idle_a: assert property (ce && s_next.mode != dtp_pkg::MD_VAR
        |=> !s_reg.grpOn && s_reg.lineCnt == 2'h0)
        else $error("line grouping kept outside variable base");
    line_count_a: assert property (s_reg.lineCnt <= dtp_pkg::LINE_LAST)
        else $error("line cycle counter out of range");

endmodule // dtp_io_point

// File: hw/dtp_pkg.sv
// Constants, carriers and register map of the digital I/O point
// ============================================================
// Functional notes
// - Point is contact input, voltage input or output
// - Dedicated input picks sensing by input-type bit
// - Contact mode: signal on while closure seen
// - Voltage mode: signal on while voltage sufficient
// - Zero holds off, full holds on, else modulate
// - Average on fraction equals commanded power
// - Fixed base: on/off split of one period
// - Period 0.1 to 60 s, fixed base only
// - Variable base: whole line cycles, groups of three
// - Low scale gives power at zero command
// - High scale gives power at full command
// - Command maps linearly between low and high
package dtp_pkg;

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TENTH_S_MS = 100;
    localparam int TENTH_S_CYC = TENTH_S_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int STEPS = 1000;
    localparam int SLOT_CYC = TENTH_S_CYC / STEPS;

    // ============================================================
    // Scales, in tenths of a percent or tenths of a second
    localparam logic [9:0] FULL = 10'h3e8;
    localparam logic [9:0] LAST_SLOT = 10'h3e7;
    localparam logic [9:0] PER_MIN = 10'h001;
    localparam logic [9:0] PER_MAX = 10'h258;
    localparam logic [1:0] LINE_LAST = 2'h2;

    // ============================================================
    // Register offsets, fields and reset values
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_LOW = 8'h08;
    localparam logic [7:0] ADDR_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam int CTRL_DIR_LSB = 0;
    localparam int CTRL_DED_BIT = 2;
    localparam int CTRL_TB_BIT = 3;
    localparam int STAT_PWR_LSB = 16;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [9:0] PER_RST = 10'h064;
    localparam logic [9:0] LOW_RST = 10'h000;
    localparam logic [9:0] HIGH_RST = 10'h3e8;
    localparam logic [9:0] CMD_RST = 10'h000;

    // ============================================================
    // Types
    typedef enum logic [1:0] {
        DIR_CONTACT = 2'h0,
        DIR_VOLT = 2'h1,
        DIR_OUTPUT = 2'h2
    } dtp_dir_t;

    typedef enum logic [1:0] {
        MD_INPUT = 2'h0,
        MD_STEADY = 2'h1,
        MD_FIXED = 2'h3,
        MD_VAR = 2'h2
    } dtp_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dtp_bus_t;

    typedef struct packed {
        logic ioContact;
        logic ioVolt;
        logic dedContact;
        logic dedVolt;
        logic acLine;
    } dtp_pins_t;

endpackage

// File: dv/dtp_field_model.sv
// Field-side model: contact and voltage sources, ac line and load
`timescale 1ns/1ps

module dtp_field_model #(
    parameter int HalfLine = 10
) (
    input wire logic clock,
    input wire logic lineRun,
    input wire logic [3:0] level,
    input wire logic fieldOut,
    input wire logic outEn,
    output dtp_pkg::dtp_pins_t pins,
    output logic loadOn
);
    // ============================================================
    // Line generator
    int phase_reg;
    logic acLine_reg;

    // Stopped line rests low so no stray group edges appear
    always_ff @(posedge clock)
    begin
        if (!lineRun)
        begin
            phase_reg <= 0;
            acLine_reg <= 1'b0;
        end
        else if (phase_reg == HalfLine - 1)
        begin
            phase_reg <= 0;
            acLine_reg <= !acLine_reg;
        end
        else
        begin
            phase_reg <= phase_reg + 1;
        end
    end

    // ============================================================
    // Pins and load
    // Level bits: io closure, io voltage, dedicated closure, dedicated voltage
    assign pins = {level[0], level[1], level[2], level[3], acLine_reg};
    // Solid-state load, so line-cycle switching is acceptable
    assign loadOn = outEn & fieldOut;
endmodule // dtp_field_model

// File: dv/tb.sv
// Self-checking testbench for the digital I/O point
`timescale 1ns/1ps

module tb;
    // ============================================================
    // Signals and tables
    typedef struct {int per; int low; int high; int cmd; int eff;} dtp_row_t;
    localparam int SlotCyc = 2;
    logic clock;
    logic rst;
    logic ce;
    logic lineRun;
    logic [3:0] lvl;
    dtp_pkg::dtp_bus_t bus;
    dtp_pkg::dtp_pins_t pins;
    logic [31:0] rdata;
    logic ioIn;
    logic dedIn;
    logic fieldOut;
    logic outEn;
    logic loadOn;
    logic [31:0] rv;
    int miscompares;
    int nTests;
    // Period, low, high, command, effective power in tenths
    dtp_row_t rows[8] = '{'{1, 0, 1000, 750, 750}, '{1, 200, 800, 500, 500},
        '{1, 0, 1000, 0, 0}, '{1, 0, 1000, 1000, 1000}, '{1, 300, 300, 0, 300},
        '{1, 1000, 0, 250, 750}, '{2, 200, 600, 1000, 600}, '{1, 0, 1000, 1, 1}};
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] rr[6] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_03e8,
        32'h0000_0000, 32'h0000_0000};
    logic [7:0] ca[4] = '{8'h04, 8'h04, 8'h10, 8'h08};
    logic [31:0] cw[4] = '{32'h0000_0000, 32'h0000_02bc, 32'h0000_07d0, 32'h0000_03e9};
    logic [31:0] cx[4] = '{32'h0000_0001, 32'h0000_0258, 32'h0000_03e8, 32'h0000_03e8};
    int vc[3] = '{250, 500, 667};

    dtp_io_point #(.SlotCycles(SlotCyc)) u_dut (.clock(clock), .rst(rst), .ce(ce), .bus(bus),
        .rdata(rdata), .pins(pins), .ioIn(ioIn), .dedIn(dedIn), .fieldOut(fieldOut),
        .outEn(outEn));
    dtp_field_model u_field (.clock(clock), .lineRun(lineRun), .level(lvl),
        .fieldOut(fieldOut), .outEn(outEn), .pins(pins), .loadOn(loadOn));

    // ============================================================
    // Clock and tasks
    // Free-running 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic printVerdict();
        if (miscompares == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic near(string name, int exp, int got, int tol);
        nTests++;
        if (got < exp - tol || got > exp + tol)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        nTests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask

    // Load on-time over n cycles, each sampled once settled
    task automatic onTime(int n, output int cnt);
        cnt = 0;
        repeat (n)
        begin
            @(posedge clock);
            #1 cnt += int'(loadOn);
        end
    endtask

    // Re-entering fixed mode reloads the duty at once
    task automatic fixedRow(dtp_row_t r);
        int cnt;
        wr(8'h04, r.per);
        wr(8'h08, r.low);
        wr(8'h0c, r.high);
        wr(8'h10, r.cmd);
        wr(8'h00, 32'h0000_0003);
        wr(8'h00, 32'h0000_0002);
        onTime(1000 * r.per * SlotCyc, cnt);
        near("fixed on time", r.eff * r.per * SlotCyc, cnt, 1);
        rd(8'h14);
        check("scaled power", r.eff, (rv >> 16) & 32'h0000_03ff);
    endtask

    // ============================================================
    // Watchdog, well beyond the expected 26k cycles
    initial
    begin
        #400000;
        miscompares++;
        printVerdict();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        int cnt;
        int e;
        miscompares = 0;
        nTests = 0;
        ce = 1'b1;
        rst = 1'b1;
        lineRun = 1'b0;
        lvl = 4'h0;
        bus = '0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            fixedRow(rows[i]);
        end
        // Second reset in mid-run, then reset values
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1 check("field after reset", 0, {fieldOut, outEn, ioIn, dedIn});
        foreach (ra[i])
        begin
            rd(ra[i]);
            check("reset value", rr[i], rv);
        end
        @(posedge clock);
        #1 check("rdata idle", 0, rdata);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14);
        check("status read-only", 0, rv);
        // Clock enable low drops the strobe
        @(posedge clock);
        ce <= 1'b0;
        wr(8'h10, 32'h0000_01f4);
        ce <= 1'b1;
        rd(8'h10);
        check("write while frozen", 0, rv);
        foreach (ca[i])
        begin
            wr(ca[i], cw[i]);
            rd(ca[i]);
            check("clamped value", cx[i], rv);
        end
        // Every direction and dedicated type against every pin level
        for (int d = 0; d < 8; d++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                wr(8'h00, d);
                lvl <= {p[1], p[0], p[1], p[0]};
                repeat (4) @(posedge clock);
                e = d[1:0] == 0 ? p[0] : d[1:0] == 1 ? p[1] : 0;
                #1 check("io input", e, ioIn);
                check("dedicated input", d[2] ? p[1] : p[0], dedIn);
                check("drive enable", d[1:0] == 2, outEn);
                if (d[1:0] != 2)
                    check("idle drive", 0, fieldOut);
                // Status mirrors the transmitted levels
                rd(8'h14);
                check("status levels", {d[2] ? p[1] : p[0], e[0]}, rv[1:0]);
            end
        end
        // Variable base on a running line
        lineRun <= 1'b1;
        wr(8'h08, 0);
        foreach (vc[i])
        begin
            wr(8'h10, vc[i]);
            wr(8'h00, 32'h0000_0003);
            wr(8'h00, 32'h0000_000a);
            onTime(1200, cnt);
            near("variable on time", vc[i] * 6 / 5, cnt, 70);
        end
        // New command mid-period waits for the period end
        lineRun <= 1'b0;
        wr(8'h04, 1);
        wr(8'h10, 250);
        wr(8'h00, 32'h0000_0003);
        wr(8'h00, 32'h0000_0002);
        wr(8'h10, 750);
        onTime(2000, cnt);
        near("first period", 500, cnt, 2);
        onTime(2000, cnt);
        near("next period", 1500, cnt, 2);
        printVerdict();
    end
endmodule // tb
